// ===== dv/sixteen_bit_reload_timer_with_capture_tb.sv
// Self-checking bench for the reload timer
module sixteen_bit_reload_timer_with_capture_tb;
	import srt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [11:0] a; logic [7:0] d, x; logic er;} srt_s;
	logic        pclk = 0, presetn = 0, ext_osc = 0;
	logic        psel, penable, pwrite, pready, pslverr, timer_irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [3:0]  pstrb;
	logic [15:0] c1;
	int          errors = 0, checked = 0, cyc = 0;
	srt_s        rows [9] = '{'{ADDR_CTRL, 8'h2B, 8'h29, 0},
		'{ADDR_CTRL, 8'h00, 8'h00, 0}, '{ADDR_CNT_LO, 8'hC3, 8'hC3, 0},
		'{ADDR_CNT_HI, 8'h3C, 8'h3C, 0}, '{ADDR_RLD_LO, 8'hA5, 8'hA5, 0},
		'{ADDR_RLD_HI, 8'h5A, 8'h5A, 0}, '{ADDR_CLKCTL, 8'h30, 8'h30, 0},
		'{ADDR_IRQEN, 8'h20, 8'h20, 0}, '{12'h01C, 8'hFF, 8'h00, 1}};
	////////////////////////////////////////////////////////////////////////
	// Clock; the oscillator pin has a five-clock period, driven on pclk
	always #10 pclk = ~pclk;
	int          osc_cnt = 0;
	always @(posedge pclk) begin
		osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
		ext_osc <= (osc_cnt < 2);
	end
	srt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_osc(ext_osc), .timer_irq(timer_irq));
	srt_host host (.pclk(pclk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, v, e);
	endtask
	task automatic rd(input logic [11:0] a);
		host.xfer(1'b0, a, 8'h00, v, e);
	endtask
	// Poll the control register until the high flag shows
	task automatic wait_hi;
		for (int i = 0; i < 300; i++) begin
			rd(ADDR_CTRL);
			if (v[CTRL_HI_FLAG] === 1'b1) break;
		end
	endtask
	task automatic test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, well above the thousand or so cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			test_done;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a);
			check(v, 32'h0);
			check(e, rows[i].er);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			check(v, rows[i].x);
			check(e, rows[i].er);
		end
		// Full wrap reloads, flags and interrupt, then stop
		wr(ADDR_CNT_LO, 8'hFE);
		wr(ADDR_CNT_HI, 8'hFF);
		wr(ADDR_CTRL, 8'h04);
		wait_hi;
		check(v[7:6], 2'b11);
		check(timer_irq, 1'b1);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_CNT_HI);
		check(v, 32'h5A);
		rd(ADDR_CNT_LO);
		c1 = v[15:0];
		rd(ADDR_CNT_LO);
		check(v, c1);
		check(timer_irq, 1'b0);
		// Low byte wrap alone interrupts only with its enable
		wr(ADDR_CNT_LO, 8'hFE);
		wr(ADDR_CNT_HI, 8'h00);
		wr(ADDR_CTRL, 8'h04);
		repeat (20) @(posedge pclk);
		rd(ADDR_CTRL);
		check(v[7:6], 2'b01);
		check(timer_irq, 1'b0);
		wr(ADDR_CTRL, 8'h60);
		repeat (3) @(posedge pclk);
		check(timer_irq, 1'b1);
		// Split: low runs without the run bit, high waits for it
		wr(ADDR_RLD_LO, 8'hF0);
		wr(ADDR_CNT_LO, 8'hF0);
		wr(ADDR_CNT_HI, 8'hFE);
		wr(ADDR_RLD_HI, 8'hC0);
		wr(ADDR_CTRL, 8'h08);
		repeat (40) @(posedge pclk);
		rd(ADDR_CTRL);
		check(v[7:6], 2'b01);
		check(timer_irq, 1'b0);
		rd(ADDR_CNT_HI);
		check(v, 32'hFE);
		rd(ADDR_CNT_LO);
		check(v[7:4], 4'hF);
		wr(ADDR_CTRL, 8'h0C);
		wait_hi;
		check(timer_irq, 1'b1);
		rd(ADDR_CNT_HI);
		check(v[7:4], 4'hC);
		// Divided clocks: one tick per 12 clocks, then per 40 clocks
		wr(ADDR_CLKCTL, 8'h00);
		wr(ADDR_CNT_LO, 8'h00);
		wr(ADDR_CTRL, 8'h04);
		repeat (240) @(posedge pclk);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_CNT_LO);
		check(v >= 19 && v <= 22, 1'b1);
		wr(ADDR_CNT_LO, 8'h00);
		wr(ADDR_CTRL, 8'h05);
		repeat (400) @(posedge pclk);
		wr(ADDR_CTRL, 8'h01);
		rd(ADDR_CNT_LO);
		check(v >= 9 && v <= 11, 1'b1);
		// Capture in 16-bit mode on the fast clock, two consecutive events 40 clocks apart
		wr(ADDR_CLKCTL, 8'h10);
		wr(ADDR_CTRL, 8'h14);
		wait_hi;
		rd(ADDR_RLD_LO);
		c1[7:0] = v[7:0];
		rd(ADDR_RLD_HI);
		c1[15:8] = v[7:0];
		wr(ADDR_CTRL, 8'h14);
		wait_hi;
		check(v[CTRL_HI_FLAG], 1'b1);
		rd(ADDR_RLD_HI);
		c1 = {v[7:0], 8'h00} - c1;
		rd(ADDR_RLD_LO);
		check(16'(c1 + v[7:0]), 16'd40);
		// Mid-run reset clears the request, control and captured high byte
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(timer_irq, 1'b0);
		rd(ADDR_CTRL);
		check(v, 32'h0);
		rd(ADDR_RLD_HI);
		check(v, 32'h0);
		test_done;
	end
endmodule

// ===== dv/srt_host.sv
// Host model: APB master standing in for the processor core
module srt_host (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	end
	// One transfer; waits for pready, the bench timeout ends a hang
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		pstrb <= 4'h1;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
endmodule

// ===== dv/srt_timer_monitor.sv
// Checker on the timer ports: APB answers and interrupt release
module srt_timer_monitor
	import srt_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ext_osc,
	input wire logic        timer_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// Read answer, and a write to the enable register turning it off
	wire rd  = pready && !pwrite;
	wire ien = psel && penable && pready && pwrite && pstrb[0]
		&& paddr == ADDR_IRQEN && !pwdata[IRQEN_TIMER];
	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_decode_a: assert property (pready |-> pslverr ==
		(paddr[1:0] != 2'b00 || paddr > ADDR_IRQEN))
		else $error("error flag wrong for address");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_top_a: assert property (rd |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	unmapped_zero_a: assert property (rd && pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	ctrl_spare_a: assert property (rd && paddr == ADDR_CTRL |-> !prdata[1])
		else $error("spare control bit reads one");
	irq_off_a: assert property (ien |-> ##2 !timer_irq)
		else $error("interrupt stays after disable");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata)) else $error("read data moved");
	// Main traffic seen
	cover property (ien);
	cover property ($rose(timer_irq));
	cover property (pready && pslverr);
endmodule

bind srt_timer srt_timer_monitor u_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ext_osc(ext_osc), .timer_irq(timer_irq));

// ===== logic/srt_pkg.sv
// Package: register map, field positions, reset values and dividers
package srt_pkg;

	// Register byte addresses on the APB bus
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_CNT_LO  = 12'h004;
	localparam logic [11:0] ADDR_CNT_HI  = 12'h008;
	localparam logic [11:0] ADDR_RLD_LO  = 12'h00C;
	localparam logic [11:0] ADDR_RLD_HI  = 12'h010;
	localparam logic [11:0] ADDR_CLKCTL  = 12'h014;
	localparam logic [11:0] ADDR_IRQEN   = 12'h018;

	// Control register fields
	localparam int CTRL_HI_FLAG  = 7;
	localparam int CTRL_LO_FLAG  = 6;
	localparam int CTRL_LO_IRQEN = 5;
	localparam int CTRL_CAP_EN   = 4;
	localparam int CTRL_SPLIT    = 3;
	localparam int CTRL_RUN      = 2;
	localparam int CTRL_EXT_SEL  = 0;
	localparam logic [7:0] CTRL_WMASK = 8'hFD;

	// Clock control fields
	localparam int CLK_HI_SEL = 5;
	localparam int CLK_LO_SEL = 4;

	// Interrupt enable field
	localparam int IRQEN_TIMER = 5;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Clock dividers
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;

endpackage

// ===== logic/srt_timer.sv
// Sixteen bit reload timer with split and capture modes, APB slave
////////////////////////////////////////////////////////////////////////////////
//
// Chosen here: the register offsets and register access over APB.

module srt_timer
	import srt_pkg::*;
#(
	parameter int SYS_DIVIDE = SYS_DIV,
	parameter int EXT_DIVIDE = EXT_DIV
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_osc,
	output logic             timer_irq
);

	// Refuse dividers the even-split toggle or 8-bit counts cannot serve
	if (SYS_DIVIDE < 1 || SYS_DIVIDE > 256 ||
	    EXT_DIVIDE < 2 || EXT_DIVIDE > 512 ||
	    (EXT_DIVIDE % 2) != 0) begin : g_bad_div
		$error("srt_timer: bad divider parameters");
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and local signals

	logic [7:0] timer_control_reg;
	logic [7:0] clock_control_reg;
	logic [7:0] interrupt_enable_reg;
	logic [7:0] count_low_byte;
	logic [7:0] count_high_byte;
	logic [7:0] reload_low_byte;
	logic [7:0] reload_high_byte;

	logic high_overflow_flag;
	logic low_overflow_flag;
	logic low_byte_irq_enable;
	logic capture_mode_enable;
	logic split_mode_select;
	logic run_control;
	logic external_clock_select;
	logic high_byte_clock_select;
	logic low_byte_clock_select;

	// Named views of the control and clock-select fields
	assign high_overflow_flag    = timer_control_reg[CTRL_HI_FLAG];
	assign low_overflow_flag     = timer_control_reg[CTRL_LO_FLAG];
	assign low_byte_irq_enable   = timer_control_reg[CTRL_LO_IRQEN];
	assign capture_mode_enable   = timer_control_reg[CTRL_CAP_EN];
	assign split_mode_select     = timer_control_reg[CTRL_SPLIT];
	assign run_control           = timer_control_reg[CTRL_RUN];
	assign external_clock_select = timer_control_reg[CTRL_EXT_SEL];
	assign high_byte_clock_select = clock_control_reg[CLK_HI_SEL];
	assign low_byte_clock_select  = clock_control_reg[CLK_LO_SEL];

	////////////////////////////////////////////////////////////////////////
	// APB decode

	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;
	logic [7:0] wbyte;

	// Only the low byte lane carries register data
	assign wbyte = pwdata[7:0];
	assign addr_ok = (paddr == ADDR_CTRL)   || (paddr == ADDR_CNT_LO) ||
	                 (paddr == ADDR_CNT_HI) || (paddr == ADDR_RLD_LO) ||
	                 (paddr == ADDR_RLD_HI) || (paddr == ADDR_CLKCTL) ||
	                 (paddr == ADDR_IRQEN);
	// Zero wait state: pready is registered high in the access phase
	assign wr_en = psel && penable && pwrite && pready && addr_ok && pstrb[0];
	assign rd_en = psel && !penable && !pwrite;

	// Answer one cycle into access so outputs stay registered
	// Error flag stands with pready for that one cycle only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	// Read data latched in setup so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (paddr)
				ADDR_CTRL:   prdata <= {24'h00_0000, timer_control_reg};
				ADDR_CNT_LO: prdata <= {24'h00_0000, count_low_byte};
				ADDR_CNT_HI: prdata <= {24'h00_0000, count_high_byte};
				ADDR_RLD_LO: prdata <= {24'h00_0000, reload_low_byte};
				ADDR_RLD_HI: prdata <= {24'h00_0000, reload_high_byte};
				ADDR_CLKCTL: prdata <= {24'h00_0000, clock_control_reg};
				ADDR_IRQEN:  prdata <= {24'h00_0000, interrupt_enable_reg};
				default:     prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock enables

	// System clock divided by SYS_DIVIDE as a one-cycle tick
	// Eight-bit count caps the divide at 256, refused above
	logic [7:0] sys_cnt;
	logic       sys_tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_cnt  <= 8'h00;
			sys_tick <= 1'b0;
		end else if (sys_cnt == 8'(SYS_DIVIDE - 1)) begin
			sys_cnt  <= 8'h00;
			sys_tick <= 1'b1;
		end else begin
			sys_cnt  <= sys_cnt + 8'h01;
			sys_tick <= 1'b0;
		end
	end

	// Pin passes two flops before any logic looks at it
	logic ext_meta;
	logic ext_sync;
	logic ext_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= ext_osc;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// External divide: toggle every EXT_DIVIDE/2 rising edges
	// Eight-bit count caps EXT_DIVIDE at 512, refused above
	logic [7:0] ext_cnt;
	logic       ext_div;
	logic       ext_div_prev;
	logic       ext_tick;
	logic       cap_event;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_cnt <= 8'h00;
			ext_div <= 1'b0;
		end else if (ext_sync && !ext_prev) begin
			if (ext_cnt == 8'(EXT_DIVIDE / 2 - 1)) begin
				ext_cnt <= 8'h00;
				ext_div <= !ext_div;
			end else begin
				ext_cnt <= ext_cnt + 8'h01;
			end
		end
	end

	// Delayed divided clock for edge detection; both reset low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ext_div_prev <= 1'b0;
		else
			ext_div_prev <= ext_div;
	end

	// Rising of divided clock counts, falling edge captures
	// Sync and divide put about three clocks between pin and tick
	assign ext_tick  = ext_div && !ext_div_prev;
	assign cap_event = capture_mode_enable && !ext_div && ext_div_prev;

	// Per-byte source select; capture mode never counts on external
	logic lo_src;
	logic hi_src;
	logic lo_tick;
	logic hi_tick;

	always_comb begin
		lo_src = external_clock_select ? ext_tick : sys_tick;
		hi_src = external_clock_select ? ext_tick : sys_tick;
		if (capture_mode_enable) begin
			lo_src = sys_tick;
			hi_src = sys_tick;
		end
		lo_tick = low_byte_clock_select ? 1'b1 : lo_src;
		hi_tick = high_byte_clock_select ? 1'b1 : hi_src;
	end

	////////////////////////////////////////////////////////////////////////
	// Counter

	logic adv_lo;
	logic adv_hi;
	logic lo_wrap;
	logic hi_wrap;

	// In 16-bit mode the high byte steps only on a low byte carry
	always_comb begin
		if (split_mode_select) begin
			adv_lo = lo_tick;
			adv_hi = hi_tick && run_control;
		end else begin
			adv_lo = lo_tick && run_control;
			adv_hi = adv_lo && (count_low_byte == 8'hFF);
		end
		lo_wrap = adv_lo && (count_low_byte == 8'hFF);
		hi_wrap = adv_hi && (count_high_byte == 8'hFF);
	end

	// Wrap reload beats a same-cycle software write of the count,
	// and a write beats the increment so a running timer can be preset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_low_byte  <= RST_BYTE;
			count_high_byte <= RST_BYTE;
		end else begin
			if (split_mode_select) begin
				if (lo_wrap)
					count_low_byte <= reload_low_byte;
				else if (wr_en && paddr == ADDR_CNT_LO)
					count_low_byte <= wbyte;
				else if (adv_lo)
					count_low_byte <= count_low_byte + 8'h01;
				if (hi_wrap)
					count_high_byte <= reload_high_byte;
				else if (wr_en && paddr == ADDR_CNT_HI)
					count_high_byte <= wbyte;
				else if (adv_hi)
					count_high_byte <= count_high_byte + 8'h01;
			end else begin
				if (hi_wrap && !capture_mode_enable) begin
					count_low_byte  <= reload_low_byte;
					count_high_byte <= reload_high_byte;
				end else begin
					// Capture mode simply rolls over
					if (wr_en && paddr == ADDR_CNT_LO)
						count_low_byte <= wbyte;
					else if (adv_lo)
						count_low_byte <= count_low_byte + 8'h01;
					if (wr_en && paddr == ADDR_CNT_HI)
						count_high_byte <= wbyte;
					else if (adv_hi)
						count_high_byte <= count_high_byte + 8'h01;
				end
			end
		end
	end

	// Reload pair: capture snapshot wins over software write
	// Pair is read as two bytes; a capture between reads tears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_low_byte  <= RST_BYTE;
			reload_high_byte <= RST_BYTE;
		end else if (cap_event) begin
			reload_low_byte  <= count_low_byte;
			reload_high_byte <= count_high_byte;
		end else begin
			if (wr_en && paddr == ADDR_RLD_LO)
				reload_low_byte <= wbyte;
			if (wr_en && paddr == ADDR_RLD_HI)
				reload_high_byte <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, flags and other configuration

	// Flags set by hardware win over a software clear in the same cycle
	// Bit one reads zero because the write mask drops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_reg <= RST_BYTE;
		end else begin
			if (wr_en && paddr == ADDR_CTRL)
				timer_control_reg <= wbyte & CTRL_WMASK;
			if (hi_wrap || cap_event)
				timer_control_reg[CTRL_HI_FLAG] <= 1'b1;
			if (lo_wrap)
				timer_control_reg[CTRL_LO_FLAG] <= 1'b1;
		end
	end

	// Plain configuration bytes with no side effects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_control_reg    <= RST_BYTE;
			interrupt_enable_reg <= RST_BYTE;
		end else if (wr_en) begin
			if (paddr == ADDR_CLKCTL)
				clock_control_reg <= wbyte;
			if (paddr == ADDR_IRQEN)
				interrupt_enable_reg <= wbyte;
		end
	end

	// Level request while a flag stands; software clears flags to drop it
	// Low flag counts only while its own enable is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= interrupt_enable_reg[IRQEN_TIMER] &&
			             (high_overflow_flag ||
			              (low_byte_irq_enable && low_overflow_flag));
	end

endmodule
